// ===== hdl/eeprom_regs.svh
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH
`define TYPE_CODE      4'ha
`define ADDR_W         10
`define COL_W          4
`define BITS_PER_BYTE  4'h8
`define WR_TIME_NS     5000000
`define CLK_PERIOD_NS  4
`define WR_CYCLES      (`WR_TIME_NS / `CLK_PERIOD_NS)
`define SCL_DIV        8'h20
`endif

// ===== hdl/eeprom_pkg.sv
`default_nettype none
package eeprom_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DEV   = 3'b001,
    ST_WADDR = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_IGN   = 3'b101
  } slave_state_t;
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_BIT = 3'b010,
    M_STOP = 3'b011,
    M_DONE = 3'b100
  } master_state_t;
endpackage
`default_nettype wire

// ===== hdl/two_wire_if.sv
`default_nettype none
interface two_wire_if;
  logic scl;
  logic sda_m_oe;
  logic sda_s_oe;
  logic sda_m_o;
  logic sda_s_o;
  logic sda;
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport mst (output scl, input sda, output sda_m_o, output sda_m_oe);
endinterface
`default_nettype wire

// ===== hdl/eeprom_dev.sv
// Contract
// - ack address when chip select matches
// - ack low word address byte
// - byte write: ack data, then stop
// - stop after write starts programming, bus ignored
// - page write programs 1-16 bytes
// - each page byte acknowledged
// - stop after page programs loaded bytes
// - only column bits increment during load
// - column wraps within row past sixteen
// - no address ack while programming
// - ack again once programming done
// - read selected by last address bit
// - counter holds last address plus one
// - current read: ack, shift byte, increment
// - master nack then stop ends read
// - master ack fetches next byte
// - counter wraps past top address
// - dummy write then read sets address
// - start after address abandons write
// - sda edges with scl high frame
// - type code must match
// - write protect blocks programming
// - ten bit word address
`default_nettype none
`include "eeprom_regs.svh"
module eeprom_dev #(
  parameter int WR_CYCLES = `WR_CYCLES
) (
  input  wire logic  ref_clk,
  input  wire logic  rst_b,
  two_wire_if.dev    bus,
  input  wire logic  chip_select_pin,
  input  wire logic  write_protect,
  output logic       busy
);
  import eeprom_pkg::*;
  // the serial clock drives the link logic; programming timer on ref_clk
  localparam int AW = `ADDR_W;
  localparam int CW = `COL_W;
  logic [7:0]    mem [0:(1<<AW)-1];
  logic [7:0]    page_q [0:(1<<CW)-1];
  logic [15:0]   page_vld_q;
  slave_state_t  st_q;
  logic [3:0]    bit_q;
  logic [7:0]    sh_q;
  logic [AW-1:0] cnt_q;
  logic          ack_ph_q;
  logic          rd_q;
  logic          start_q;
  logic          stop_q;
  logic          stop_ack_q;
  logic          prog_tgl_q;
  logic [2:0]    done_sync_q;
  logic          done_tgl_q;
  logic [1:0]    prog_sync_q;
  logic          prog_seen_q;
  logic [31:0]   tmr_q;
  logic          byte_done;
  logic          prog_busy;
  // ---------------------------------------------------------------
  // start and stop detection on sda edges while scl high
  // ---------------------------------------------------------------
  always_ff @(negedge bus.sda or negedge rst_b) begin
    if (!rst_b) start_q <= 1'b0;
    else if (bus.scl) start_q <= ~start_q;
  end
  // programming starts on the stop edge itself: scl stays high after a stop,
  // so waiting for the next scl edge would delay it to the next frame
  always_ff @(posedge bus.sda or negedge rst_b) begin
    if (!rst_b) begin
      stop_q <= 1'b0;
      prog_tgl_q <= 1'b0;
    end else if (bus.scl) begin
      stop_q <= ~stop_q;
      if (page_vld_q != 16'h0 && !write_protect) begin
        prog_tgl_q <= ~prog_tgl_q;
      end
    end
  end
  logic start_seen_q;
  logic stop_seen_q;
  always_ff @(posedge bus.scl or negedge rst_b) begin
    if (!rst_b) begin
      start_seen_q <= 1'b0;
    end else begin
      start_seen_q <= start_q;
    end
  end
  wire start_ev = (start_seen_q != start_q);
  // ---------------------------------------------------------------
  // programming handshake: toggle into ref_clk, done toggled back
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prog_sync_q <= 2'b00;
      prog_seen_q <= 1'b0;
      tmr_q <= 32'h0;
      done_tgl_q <= 1'b0;
      stop_seen_q <= 1'b0;
    end else begin
      prog_sync_q <= {prog_sync_q[0], prog_tgl_q};
      if (prog_sync_q[1] != prog_seen_q) begin
        prog_seen_q <= prog_sync_q[1];
        tmr_q <= WR_CYCLES[31:0];
      end else if (tmr_q == 32'h1) begin
        tmr_q <= 32'h0;
        done_tgl_q <= ~done_tgl_q;
      end else if (tmr_q != 32'h0) begin
        tmr_q <= tmr_q - 32'h1;
      end
      stop_seen_q <= 1'b0;
    end
  end
  assign busy = (tmr_q != 32'h0) || (prog_sync_q[1] != prog_seen_q);
  // busy seen from the link side, compared against the returned toggle
  always_ff @(posedge bus.scl or negedge rst_b) begin
    if (!rst_b) done_sync_q <= 3'b000;
    else done_sync_q <= {done_sync_q[1:0], done_tgl_q};
  end
  assign prog_busy = (prog_tgl_q != done_sync_q[2]);
  // ---------------------------------------------------------------
  // byte shifter and protocol state, on scl
  // ---------------------------------------------------------------
  assign byte_done = (bit_q == `BITS_PER_BYTE - 4'h1);
  always_ff @(posedge bus.scl or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h0;
      cnt_q <= '0;
      ack_ph_q <= 1'b0;
      rd_q <= 1'b0;
      page_vld_q <= 16'h0;
      stop_ack_q <= 1'b0;
    end else if (start_ev) begin
      st_q <= ST_DEV;
      bit_q <= 4'h1;
      sh_q <= {7'h0, bus.sda};
      ack_ph_q <= 1'b0;
      page_vld_q <= 16'h0;
      stop_ack_q <= stop_q;
    end else if (stop_q != stop_ack_q) begin
      stop_ack_q <= stop_q;
      st_q <= ST_IDLE;
      page_vld_q <= 16'h0;
    end else if (ack_ph_q) begin
      ack_ph_q <= 1'b0;
      bit_q <= 4'h0;
      // read address ack is ours; data starts only after it
      if (st_q == ST_DEV) st_q <= ST_RDATA;
      if (st_q == ST_RDATA && bus.sda) st_q <= ST_IGN;
    end else if (st_q != ST_IDLE && st_q != ST_IGN) begin
      sh_q <= {sh_q[6:0], bus.sda};
      bit_q <= bit_q + 4'h1;
      if (byte_done) begin
        ack_ph_q <= 1'b1;
        case (st_q)
          ST_DEV: begin
            if (sh_q[6:3] == `TYPE_CODE && sh_q[2] == chip_select_pin
                && !prog_busy) begin
              rd_q <= bus.sda;
              cnt_q[9:8] <= sh_q[1:0];
              st_q <= bus.sda ? ST_DEV : ST_WADDR;
              if (bus.sda) cnt_q[9:8] <= cnt_q[9:8];
            end else begin
              st_q <= ST_IGN;
              ack_ph_q <= 1'b0;
            end
          end
          ST_WADDR: begin
            cnt_q[7:0] <= {sh_q[6:0], bus.sda};
            st_q <= ST_WDATA;
          end
          ST_WDATA: begin
            page_q[cnt_q[CW-1:0]] <= {sh_q[6:0], bus.sda};
            page_vld_q[cnt_q[CW-1:0]] <= 1'b1;
            cnt_q[CW-1:0] <= cnt_q[CW-1:0] + 4'h1;
          end
          ST_RDATA: cnt_q <= cnt_q + 10'h1;
          default: st_q <= ST_IGN;
        endcase
      end
    end
  end
  // ---------------------------------------------------------------
  // array write on stop; reads use the current counter
  // ---------------------------------------------------------------
  always_ff @(posedge bus.sda) begin
    if (bus.scl && !write_protect) begin
      for (int i = 0; i < 16; i++) begin
        if (page_vld_q[i]) mem[{cnt_q[AW-1:CW], i[CW-1:0]}] <= page_q[i];
      end
    end
  end
  // ---------------------------------------------------------------
  // sda drive, changes on scl falling edge
  // ---------------------------------------------------------------
  logic       oe_q;
  logic       o_q;
  logic [7:0] rd_sh_q;
  always_ff @(negedge bus.scl or negedge rst_b) begin
    if (!rst_b) begin
      oe_q <= 1'b0;
      o_q <= 1'b1;
      rd_sh_q <= 8'hff;
    end else if (ack_ph_q && st_q != ST_RDATA) begin
      oe_q <= 1'b1;
      o_q <= 1'b0;
    end else if (st_q == ST_RDATA && !ack_ph_q && bit_q == 4'h0) begin
      oe_q <= 1'b1;
      o_q <= mem[cnt_q][7];
      rd_sh_q <= {mem[cnt_q][6:0], 1'b1};
    end else if (st_q == ST_RDATA && !ack_ph_q && bit_q < 4'h8) begin
      oe_q <= 1'b1;
      o_q <= rd_sh_q[7];
      rd_sh_q <= {rd_sh_q[6:0], 1'b1};
    end else begin
      oe_q <= 1'b0;
      o_q <= 1'b1;
    end
  end
  assign bus.sda_s_oe = oe_q;
  assign bus.sda_s_o = o_q;
endmodule // eeprom_dev
`default_nettype wire

// ===== hdl/eeprom_host.sv
`default_nettype none
`include "eeprom_regs.svh"
module eeprom_host (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  two_wire_if.mst   bus,
  input  wire logic req_valid,
  output logic      req_ready,
  input  wire logic [8:0] req_word,
  input  wire logic req_start,
  input  wire logic req_stop,
  output logic      rsp_valid,
  output logic [7:0] rsp_data,
  output logic      rsp_ack
);
  import eeprom_pkg::*;
  // req_word[8] is the ack bit to send after a read byte (1 = nack)
  master_state_t st_q;
  logic [7:0] div_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [8:0] sh_q;
  logic [8:0] in_q;
  logic       stop_q;
  logic       scl_q;
  logic       sda_q;
  logic [1:0] sda_sync_q;
  wire tick = (div_q == 8'h0);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) sda_sync_q <= 2'b11;
    else sda_sync_q <= {sda_sync_q[0], bus.sda};
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) div_q <= 8'h0;
    else div_q <= tick ? `SCL_DIV : div_q - 8'h1;
  end
  assign req_ready = (st_q == M_IDLE);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= M_IDLE;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= 9'h1ff;
      in_q <= 9'h0;
      stop_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h0;
      rsp_ack <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (st_q)
        M_IDLE: if (req_valid) begin
          sh_q <= {req_word[7:0], req_word[8]};
          stop_q <= req_stop;
          bit_q <= 4'h0;
          ph_q <= 2'h0;
          st_q <= req_start ? M_START : M_BIT;
        end
        M_START: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_q <= 1'b1;
            2'h1: scl_q <= 1'b1;
            2'h2: sda_q <= 1'b0;
            default: begin
              scl_q <= 1'b0;
              st_q <= M_BIT;
            end
          endcase
        end
        M_BIT: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_q <= sh_q[8];
            2'h1: scl_q <= 1'b1;
            2'h2: in_q <= {in_q[7:0], sda_sync_q[1]};
            default: begin
              scl_q <= 1'b0;
              sh_q <= {sh_q[7:0], 1'b1};
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h8) st_q <= stop_q ? M_STOP : M_DONE;
            end
          endcase
        end
        M_STOP: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_q <= 1'b0;
            2'h1: scl_q <= 1'b1;
            2'h2: sda_q <= 1'b1;
            default: st_q <= M_DONE;
          endcase
        end
        M_DONE: begin
          rsp_valid <= 1'b1;
          rsp_data <= in_q[8:1];
          rsp_ack <= ~in_q[0];
          st_q <= M_IDLE;
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end
  assign bus.scl = scl_q;
  assign bus.sda_m_oe = ~sda_q;
  assign bus.sda_m_o = 1'b0;
endmodule // eeprom_host
`default_nettype wire

// ===== testbench/eeprom_chk.sv
`default_nettype none
module eeprom_chk (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic sda_m_o,
  input wire logic sda_s_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q;
  logic sda_q;
  logic rw_q;
  int   cnt_q;
  logic dev_low;
  logic mst_low;
  logic rise;
  logic start;
  logic stop;
  assign dev_low = sda_s_oe & ~sda_s_o;
  assign mst_low = sda_m_oe & ~sda_m_o;
  assign rise = scl & ~scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop = scl & scl_q & ~sda_q & sda;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // bits counted per frame; a repeated start restarts the count
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) cnt_q <= 0;
    else if (start) cnt_q <= 0;
    else if (rise) cnt_q <= cnt_q + 1;
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) rw_q <= 1'b0;
    else if (rise && cnt_q == 7) rw_q <= sda;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_addr_quiet; rise && cnt_q < 8 |-> !dev_low; endproperty
  property p_wr_ack_only; rise && !rw_q && cnt_q >= 8 && cnt_q % 9 != 8 |-> !dev_low; endproperty
  property p_rd_release; rise && rw_q && cnt_q >= 17 && cnt_q % 9 == 8 |-> !dev_low; endproperty
  property p_dev_edge; $changed(dev_low) |-> !scl; endproperty
  // both may pull low at the scl fall that hands the line over
  property p_no_fight; rise && dev_low |-> !mst_low; endproperty
  property p_stop_quiet; stop |=> !dev_low [*8]; endproperty
  property p_scl_high; rise |-> scl [*8]; endproperty
  property p_start_low; start |-> ##[1:300] !scl; endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("address bit pulled");
  a_wr_ack_only: assert property (p_wr_ack_only) else $error("write bit pulled");
  a_rd_release: assert property (p_rd_release) else $error("ack slot held");
  a_dev_edge: assert property (p_dev_edge) else $error("sda moved, scl high");
  a_no_fight: assert property (p_no_fight) else $error("both drive sda");
  a_stop_quiet: assert property (p_stop_quiet) else $error("sda held after stop");
  a_scl_high: assert property (p_scl_high) else $error("scl high too short");
  a_start_low: assert property (p_start_low) else $error("scl stuck after start");
  c_page: cover property (rise && !rw_q && cnt_q == 35 && dev_low);
  c_read: cover property (rise && rw_q && cnt_q == 8 && dev_low);
  c_stop: cover property (stop);
endmodule // eeprom_chk
`default_nettype wire

// ===== testbench/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import eeprom_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       cs_pin = 1'b1;
  logic       wp = 1'b0;
  logic       busy;
  logic       req_valid = 1'b0;
  logic       req_ready;
  logic [8:0] req_word = 9'h1ff;
  logic       req_start = 1'b0;
  logic       req_stop = 1'b0;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       rsp_ack;
  logic       a;
  logic [7:0] d;
  logic [7:0] foreign [0:3] = '{8'ha0, 8'hbe, 8'h2e, 8'ha1};
  int         fail_count = 0;
  int         comparisons = 0;
  two_wire_if link ();
  always #2 ref_clk = ~ref_clk;
  // programming time shortened so polling sees both answers
  eeprom_dev #(.WR_CYCLES(3000)) eeprom_dev_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .bus(link.dev), .chip_select_pin(cs_pin), .write_protect(wp), .busy(busy));
  eeprom_host eeprom_host_inst (.ref_clk(ref_clk), .rst_b(rst_b), .bus(link.mst),
    .req_valid(req_valid), .req_ready(req_ready), .req_word(req_word),
    .req_start(req_start), .req_stop(req_stop), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  eeprom_chk eeprom_chk_inst (.ref_clk(ref_clk), .rst_b(rst_b), .scl(link.scl),
    .sda(link.sda), .sda_m_oe(link.sda_m_oe), .sda_s_oe(link.sda_s_oe),
    .sda_m_o(link.sda_m_o), .sda_s_o(link.sda_s_o));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic xfer(input logic [8:0] w, input logic s, input logic p);
    int n;
    n = 0;
    @(negedge ref_clk);
    req_word = w;
    req_start = s;
    req_stop = p;
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    chk({7'h0, rsp_valid}, 8'h01, "response");
    a = rsp_ack;
    d = rsp_data;
  endtask
  task automatic cmd(input logic [7:0] w, input logic s, input logic p, input logic ack);
    xfer({1'b1, w}, s, p);
    chk({7'h0, a}, {7'h0, ack}, "ack");
  endtask
  task automatic rdb(input logic nack, input logic p, input logic [7:0] exp);
    xfer({nack, 8'hff}, 1'b0, p);
    chk(d, exp, "read data");
  endtask
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 5000) begin
      @(negedge ref_clk);
      n++;
    end
    chk({7'h0, busy}, {7'h0, v}, "busy");
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #380000;
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    rst_b = 1'b1;
    cmd(8'hae, 1, 0, 1);
    cmd(8'hff, 0, 0, 1);
    cmd(8'ha5, 0, 1, 1);
    wait_busy(1'b1);
    cmd(8'hae, 1, 1, 0);
    wait_busy(1'b0);
    cmd(8'hae, 1, 1, 1);
    cmd(8'ha8, 1, 0, 1);
    cmd(8'h00, 0, 0, 1);
    cmd(8'h3c, 0, 1, 1);
    wait_busy(1'b1);
    wait_busy(1'b0);
    $display("byte write done");
    foreach (foreign[i]) cmd(foreign[i], 1, 1, 0);
    $display("foreign address done");
    cmd(8'ha8, 1, 0, 1);
    cmd(8'h1f, 0, 0, 1);
    for (int i = 0; i < 17; i++) cmd(8'h40 + 8'(i), 0, i == 16, 1);
    wait_busy(1'b1);
    wait_busy(1'b0);
    cmd(8'ha8, 1, 0, 1);
    cmd(8'h1e, 0, 0, 1);
    cmd(8'ha9, 1, 0, 1);
    rdb(1'b0, 0, 8'h4f);
    rdb(1'b1, 1, 8'h50);
    chk({7'h0, busy}, 8'h00, "abandoned write");
    $display("page write done");
    cmd(8'hae, 1, 0, 1);
    cmd(8'hff, 0, 0, 1);
    cmd(8'haf, 1, 0, 1);
    rdb(1'b1, 1, 8'ha5);
    cmd(8'ha9, 1, 0, 1);
    rdb(1'b1, 1, 8'h3c);
    $display("wrap read done");
    wp = 1'b1;
    xfer({1'b1, 8'ha8}, 1, 0);
    xfer({1'b1, 8'h00}, 0, 0);
    xfer({1'b1, 8'hc3}, 0, 1);
    wait_busy(1'b0);
    cmd(8'ha8, 1, 0, 1);
    cmd(8'h00, 0, 0, 1);
    cmd(8'ha9, 1, 0, 1);
    rdb(1'b1, 1, 8'h3c);
    wp = 1'b0;
    $display("write protect done");
    end_sim();
  end
endmodule // testbench
`default_nettype wire
